// *** include/eth_mac_ctrl_pkg.sv ***
package eth_mac_ctrl_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses, one 32-bit word each)
    // ------------------------------------------------------------------
    localparam int APB_AW = 8;
    localparam logic [APB_AW-1:0] OFS_EVENT_FLAGS = 8'h00;
    localparam logic [APB_AW-1:0] OFS_EVENT_ENABLE = 8'h04;
    localparam logic [APB_AW-1:0] OFS_MGMT_PORT = 8'h08;
    localparam logic [APB_AW-1:0] OFS_ADDR_UPPER = 8'h0c;
    localparam logic [APB_AW-1:0] OFS_ADDR_LOWER = 8'h10;
    localparam logic [APB_AW-1:0] OFS_RX_MAX_LEN = 8'h14;
    localparam logic [APB_AW-1:0] OFS_LINK_STATUS = 8'h18;
    localparam logic [APB_AW-1:0] OFS_RETRY_COUNT = 8'h1c;

    // ------------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------------
    localparam int EV_LINK_POS = 2;
    localparam int EV_WAKE_POS = 1;
    localparam int EV_CARRIER_POS = 0;
    localparam int MGMT_IN_POS = 3;
    localparam int MGMT_OUT_POS = 2;
    localparam int MGMT_DIR_POS = 1;
    localparam int MGMT_MDC_POS = 0;
    localparam int LINK_MON_POS = 0;
    localparam int RFL_W = 12;
    localparam int ADDR_LO_W = 16;

    // ------------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------------
    localparam logic [2:0] EVENT_ENABLE_RST = 3'h0;
    localparam logic [2:0] EVENT_FLAGS_RST = 3'h0;
    localparam logic [31:0] ADDR_UPPER_RST = 32'h0000_0000;
    localparam logic [15:0] ADDR_LOWER_RST = 16'h0000;
    localparam logic [11:0] RFL_RST = 12'h000;

    // ------------------------------------------------------------------
    // Receive length decode and frame constants
    // ------------------------------------------------------------------
    localparam logic [11:0] RFL_FLOOR_CODE = 12'h5ee;
    localparam logic [11:0] RFL_CAP_CODE = 12'h800;
    localparam logic [11:0] RX_LEN_FLOOR = 12'h5ee;
    localparam logic [11:0] RX_LEN_CAP = 12'h800;
    localparam int CRC_BYTES = 4;
    localparam int RETRY_LIMIT_TRIES = 16;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [APB_AW-1:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_s;

    typedef struct packed {
        logic valid;
        logic last;
        logic [7:0] data;
    } rx_byte_s;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic done;
        logic truncated;
    } rx_mem_s;

    typedef enum logic [1:0] {
        RX_RUN = 2'b01,
        RX_FLUSH = 2'b10
    } rx_state_e;

endpackage : eth_mac_ctrl_pkg

// *** test/phy_model.sv ***
`timescale 1ns/1ps
module phy_model (
    // Management pins
    input wire logic mdc,
    input wire logic mdio_o,
    input wire logic mdio_oe,
    output logic mdio_i,
    // Bench control
    input wire logic drv_en,
    input wire logic drv_val,
    input wire logic link_set,
    // Link status pin
    output logic phy_link_pin
);
    logic lclk = 1'b0;

    // The link pin moves on the transceiver's own 48 ns clock, unrelated to the core clock.
    always #24 lclk = ~lclk;

    initial phy_link_pin = 1'b1;

    always @(posedge lclk) begin
        phy_link_pin <= link_set;
    end

    // The line has a pull-up, so a released line reads high; both ends driving is contention.
    assign mdio_i = mdio_oe ? (drv_en ? 1'bx : mdio_o) : (drv_en ? drv_val : 1'b1);
endmodule : phy_model

// *** test/tb_eth_mac_ctrl_regs.sv ***
`timescale 1ns/1ps
module tb_eth_mac_ctrl_regs;
    import eth_mac_ctrl_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    apb_req_s req = '0;
    apb_rsp_s rsp;
    rx_byte_s rx_in = '0;
    rx_mem_s rx_out;
    logic irq, mdc, mdio_i, mdio_o, mdio_oe, link_pin, perr;
    logic wake = 1'b0, carrier = 1'b0, retry = 1'b0;
    logic drv_en = 1'b0, drv_val = 1'b0, link_set = 1'b1;
    logic rx_done = 1'b0, rx_trunc = 1'b0;
    logic [47:0] st_addr;
    logic [31:0] rd;
    int fails = 0, check_count = 0, cyc = 0, rx_cnt = 0;
    int fc[9] = '{12'h000, 12'h000, 12'h000, 12'h5ee, 12'h5ef, 12'h5f0, 12'h7ff, 12'h800, 12'hfff};
    int fl[9] = '{64, 1518, 1519, 1519, 1519, 1600, 2047, 2100, 2049};
    int fn[9] = '{60, 1514, 1518, 1518, 1515, 1520, 2043, 2048, 2048};

    always #2.5 clk = ~clk;

    // A small counter width keeps the saturation test short.
    eth_mac_ctrl_regs #(.RETRY_W(4)) dut (.clk(clk), .rst_n(rst_n), .apb_req(req),
        .apb_rsp(rsp), .irq(irq), .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o),
        .mdio_oe(mdio_oe), .phy_link_pin(link_pin), .wake_packet_seen(wake),
        .bad_carrier_seen(carrier), .tx_retry_fail(retry), .rx_in(rx_in),
        .rx_out(rx_out), .station_addr(st_addr));

    phy_model phy (.mdc(mdc), .mdio_o(mdio_o), .mdio_oe(mdio_oe), .mdio_i(mdio_i),
        .drv_en(drv_en), .drv_val(drv_val), .link_set(link_set), .phy_link_pin(link_pin));

    // --------------------------------------------------------------
    // Checking and bus tasks
    // --------------------------------------------------------------
    task summarize;
        if (fails == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    task chk(input logic [47:0] got, input logic [47:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        // The answer is taken at the rising edge that samples pready high.
        do begin
            @(posedge clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 50);
        if (rsp.pready !== 1'b1) begin
            fails++;
        end
        rd = rsp.prdata;
        perr = rsp.pslverr;
        req <= '0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdc

    task irqc(input logic exp);
        repeat (2) @(negedge clk);
        chk(irq, exp);
    endtask : irqc

    // Event 0 carrier, 1 wake packet, 2 link toggle, 3 retry failure.
    task pulse(input int i);
        @(posedge clk);
        case (i)
            0: carrier <= 1'b1;
            1: wake <= 1'b1;
            2: link_set <= ~link_set;
            default: retry <= 1'b1;
        endcase
        @(posedge clk);
        carrier <= 1'b0;
        wake <= 1'b0;
        retry <= 1'b0;
        repeat (16) @(posedge clk);
    endtask : pulse

    task frame(input logic [11:0] code, input int len, input int exp_n, input logic exp_t);
        int k, n;
        wr(OFS_RX_MAX_LEN, {20'h0, code});
        rx_cnt = 0;
        rx_done = 1'b0;
        for (k = 0; k < len; k++) begin
            @(posedge clk);
            rx_in <= {1'b1, k == len - 1, k[7:0]};
        end
        @(posedge clk);
        rx_in <= '0;
        n = 0;
        while (rx_done !== 1'b1 && n < 30) begin
            @(posedge clk);
            n++;
        end
        repeat (6) @(posedge clk);
        chk(rx_cnt, exp_n);
        chk(rx_trunc, exp_t);
    endtask : frame

    // Bytes must come out in order, each one once.
    always @(negedge clk) begin
        if (rx_out.valid === 1'b1) begin
            chk(rx_out.data, rx_cnt[7:0]);
            rx_cnt++;
        end
        if (rx_out.done === 1'b1) begin
            rx_done = 1'b1;
            rx_trunc = rx_out.truncated;
        end
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            fails++;
            summarize();
        end
    end

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rdc(OFS_EVENT_ENABLE, 32'h0);
        rdc(OFS_EVENT_FLAGS, 32'h0);
        rdc(OFS_ADDR_UPPER, 32'h0);
        rdc(OFS_ADDR_LOWER, 32'h0);
        rdc(OFS_RETRY_COUNT, 32'h0);
        rdc(OFS_MGMT_PORT, 32'h8);
        wr(OFS_EVENT_ENABLE, 32'hffff_ffff);
        rdc(OFS_EVENT_ENABLE, 32'h7);
        wr(OFS_LINK_STATUS, 32'hffff_ffff);
        rdc(OFS_LINK_STATUS, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        chk({perr, rd}, 33'h1_0000_0000);
        for (int i = 0; i < 3; i++) begin
            wr(OFS_EVENT_ENABLE, 32'h7 ^ (32'h1 << i));
            pulse(i);
            irqc(1'b0);
            rdc(OFS_EVENT_FLAGS, 32'h1 << i);
            wr(OFS_EVENT_ENABLE, 32'h1 << i);
            irqc(1'b1);
            wr(OFS_EVENT_FLAGS, 32'h7 ^ (32'h1 << i));
            irqc(1'b1);
            wr(OFS_EVENT_FLAGS, 32'h1 << i);
            irqc(1'b0);
        end
        rdc(OFS_LINK_STATUS, 32'h1);
        wr(OFS_EVENT_ENABLE, 32'h7);
        pulse(0);
        pulse(1);
        wr(OFS_EVENT_FLAGS, 32'h1);
        irqc(1'b1);
        wr(OFS_EVENT_FLAGS, 32'h2);
        irqc(1'b0);
        wr(OFS_MGMT_PORT, 32'hffff_fff7);
        irqc(1'b0);
        chk({mdc, mdio_oe, mdio_o}, 3'b111);
        rdc(OFS_MGMT_PORT, 32'hf);
        wr(OFS_MGMT_PORT, 32'h2);
        irqc(1'b0);
        chk({mdc, mdio_oe, mdio_o}, 3'b010);
        rdc(OFS_MGMT_PORT, 32'h2);
        wr(OFS_MGMT_PORT, 32'h5);
        // Pins launched by the write edge are looked at once they have settled.
        @(negedge clk);
        chk({mdc, mdio_oe, mdio_o}, 3'b101);
        drv_en <= 1'b1;
        rdc(OFS_MGMT_PORT, 32'h5);
        drv_val <= 1'b1;
        // The pin passes two synchroniser stages before the register shows it.
        repeat (3) @(posedge clk);
        rdc(OFS_MGMT_PORT, 32'hd);
        drv_en <= 1'b0;
        wr(OFS_ADDR_UPPER, 32'h0123_4567);
        wr(OFS_ADDR_LOWER, 32'hffff_89ab);
        rdc(OFS_ADDR_UPPER, 32'h0123_4567);
        rdc(OFS_ADDR_LOWER, 32'h0000_89ab);
        chk(st_addr, 48'h0123_4567_89ab);
        repeat (3) pulse(3);
        rdc(OFS_RETRY_COUNT, 32'h3);
        wr(OFS_RETRY_COUNT, 32'h0000_5a5a);
        rdc(OFS_RETRY_COUNT, 32'h0);
        repeat (17) pulse(3);
        rdc(OFS_RETRY_COUNT, 32'hf);
        wr(OFS_RX_MAX_LEN, 32'hffff_ffff);
        rdc(OFS_RX_MAX_LEN, 32'hfff);
        for (int i = 0; i < 9; i++) begin
            frame(fc[i][11:0], fl[i], fn[i], fl[i] - 4 != fn[i]);
        end
        summarize();
    end
endmodule : tb_eth_mac_ctrl_regs

// *** verilog/eth_mac_ctrl_regs.sv ***
`timescale 1ns/1ps
module eth_mac_ctrl_regs
    import eth_mac_ctrl_pkg::*;
#(
    parameter int RETRY_W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register bus
    input wire apb_req_s apb_req,
    output apb_rsp_s apb_rsp,
    // Interrupt
    output logic irq,
    // Management port towards the PHY
    output logic mdc,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe,
    // PHY link pin
    input wire logic phy_link_pin,
    // Events from the MAC core
    input wire logic wake_packet_seen,
    input wire logic bad_carrier_seen,
    input wire logic tx_retry_fail,
    // Receive path
    input wire rx_byte_s rx_in,
    output rx_mem_s rx_out,
    output logic [47:0] station_addr
);

    // ------------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------------
    if (RETRY_W < 1 || RETRY_W > 16) begin : g_bad_retry_w
        $error("RETRY_W must lie between 1 and 16");
    end

    typedef struct packed {
        logic [2:0] enable;
        logic [2:0] flags;
        logic mgmt_out;
        logic mgmt_dir;
        logic mgmt_clk;
        logic mdio_s1;
        logic mdio_s2;
        logic link_s1;
        logic link_s2;
        logic link_prev;
        logic [31:0] addr_hi;
        logic [15:0] addr_lo;
        logic [11:0] rx_length_limit_field;
        logic [RETRY_W-1:0] retry;
        apb_rsp_s rsp;
        logic irq;
        rx_state_e rx_st;
        logic [15:0] rx_cnt;
        logic [3:0][7:0] line;
        logic [2:0] fill;
        rx_mem_s out;
    } ctrl_state_s;

    ctrl_state_s st_q;
    ctrl_state_s st_d;
    logic access;
    logic commit_wr;
    logic [11:0] limit;
    logic [31:0] rd_data;
    logic rd_err;
    logic link_toggle;

    // ------------------------------------------------------------------
    // Receive length decode
    // ------------------------------------------------------------------
    // Codes at or below the floor all mean the standard maximum frame, and codes at or
    // above the cap all mean the longest frame that is ever accepted.
    function automatic logic [11:0] rx_limit(input logic [11:0] code);
        logic [11:0] res;
        res = code;
        if (code <= RFL_FLOOR_CODE) begin
            res = RX_LEN_FLOOR;
        end else if (code >= RFL_CAP_CODE) begin
            res = RX_LEN_CAP;
        end
        return res;
    endfunction : rx_limit

    assign limit = rx_limit(st_q.rx_length_limit_field);
    assign access = apb_req.psel & apb_req.penable;
    // A write lands only on the edge that also samples pready high.
    assign commit_wr = access & st_q.rsp.pready & apb_req.pwrite;
    assign link_toggle = st_q.link_s2 ^ st_q.link_prev;

    // ------------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------------
    // Read data are captured in the first access cycle, so the master must hold paddr
    // steady through the whole access phase.
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_err = 1'b0;
        case (apb_req.paddr)
            OFS_EVENT_FLAGS: rd_data[2:0] = st_q.flags;
            OFS_EVENT_ENABLE: rd_data[2:0] = st_q.enable;
            OFS_MGMT_PORT: begin
                rd_data[MGMT_IN_POS] = st_q.mdio_s2;
                rd_data[MGMT_OUT_POS] = st_q.mgmt_out;
                rd_data[MGMT_DIR_POS] = st_q.mgmt_dir;
                rd_data[MGMT_MDC_POS] = st_q.mgmt_clk;
            end
            OFS_ADDR_UPPER: rd_data = st_q.addr_hi;
            OFS_ADDR_LOWER: rd_data[ADDR_LO_W-1:0] = st_q.addr_lo;
            OFS_RX_MAX_LEN: rd_data[RFL_W-1:0] = st_q.rx_length_limit_field;
            OFS_LINK_STATUS: rd_data[LINK_MON_POS] = ~st_q.link_s2;
            OFS_RETRY_COUNT: rd_data[RETRY_W-1:0] = st_q.retry;
            default: rd_err = 1'b1;
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_d = st_q;

        // Bus answer: one wait state, read data captured with pready.
        st_d.rsp.pready = access & ~st_q.rsp.pready;
        st_d.rsp.pslverr = access & ~st_q.rsp.pready & rd_err;
        st_d.rsp.prdata = (access & ~st_q.rsp.pready & ~apb_req.pwrite) ? rd_data : 32'h0;

        // Pin synchronisers; only the second stage is read by logic.
        st_d.mdio_s1 = mdio_i;
        st_d.mdio_s2 = st_q.mdio_s1;
        st_d.link_s1 = phy_link_pin;
        st_d.link_s2 = st_q.link_s1;
        st_d.link_prev = st_q.link_s2;

        // Register writes; reserved bits are simply not stored.
        if (commit_wr) begin
            case (apb_req.paddr)
                OFS_EVENT_FLAGS: st_d.flags = st_q.flags & ~apb_req.pwdata[2:0];
                OFS_EVENT_ENABLE: st_d.enable = apb_req.pwdata[2:0];
                OFS_MGMT_PORT: begin
                    st_d.mgmt_out = apb_req.pwdata[MGMT_OUT_POS];
                    st_d.mgmt_dir = apb_req.pwdata[MGMT_DIR_POS];
                    st_d.mgmt_clk = apb_req.pwdata[MGMT_MDC_POS];
                end
                OFS_ADDR_UPPER: st_d.addr_hi = apb_req.pwdata;
                OFS_ADDR_LOWER: st_d.addr_lo = apb_req.pwdata[ADDR_LO_W-1:0];
                OFS_RX_MAX_LEN: st_d.rx_length_limit_field = apb_req.pwdata[RFL_W-1:0];
                OFS_RETRY_COUNT: st_d.retry = '0;
                default: ;
            endcase
        end

        // Events set after the clear so a coincident event is kept.
        if (link_toggle) begin
            st_d.flags[EV_LINK_POS] = 1'b1;
        end
        if (wake_packet_seen) begin
            st_d.flags[EV_WAKE_POS] = 1'b1;
        end
        if (bad_carrier_seen) begin
            st_d.flags[EV_CARRIER_POS] = 1'b1;
        end

        // A failure in the clearing cycle counts from zero unless the counter was saturated; then it is lost.
        if (tx_retry_fail && st_q.retry != '1) begin
            st_d.retry = RETRY_W'(st_d.retry + 1'b1);
        end

        st_d.irq = |(st_d.flags & st_d.enable);

        // Receive path: a four-byte delay line holds back the CRC.
        st_d.out.valid = 1'b0;
        st_d.out.done = 1'b0;
        st_d.out.truncated = 1'b0;
        case (st_q.rx_st)
            RX_RUN: begin
                if (rx_in.valid) begin
                    if (st_q.rx_cnt < {4'h0, limit}) begin
                        st_d.line = {st_q.line[2:0], rx_in.data};
                        if (st_q.fill == 3'(CRC_BYTES)) begin
                            st_d.out.valid = 1'b1;
                            st_d.out.data = st_q.line[3];
                        end else begin
                            st_d.fill = st_q.fill + 3'd1;
                        end
                    end
                    if (st_q.rx_cnt != 16'hffff) begin
                        st_d.rx_cnt = st_q.rx_cnt + 16'd1;
                    end
                    if (rx_in.last) begin
                        st_d.rx_cnt = 16'h0000;
                        if (st_q.rx_cnt >= {4'h0, limit}) begin
                            // Held bytes are payload: flush them.
                            st_d.rx_st = RX_FLUSH;
                        end else begin
                            // Held bytes are the CRC: drop them.
                            st_d.fill = 3'd0;
                            st_d.out.done = 1'b1;
                        end
                    end
                end
            end
            RX_FLUSH: begin
                st_d.out.valid = 1'b1;
                st_d.out.data = st_q.line[st_q.fill - 3'd1];
                st_d.fill = st_q.fill - 3'd1;
                if (st_q.fill == 3'd1) begin
                    st_d.out.done = 1'b1;
                    st_d.out.truncated = 1'b1;
                    st_d.rx_st = RX_RUN;
                end
            end
            default: st_d.rx_st = RX_RUN;
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
            st_q.enable <= EVENT_ENABLE_RST;
            st_q.flags <= EVENT_FLAGS_RST;
            st_q.addr_hi <= ADDR_UPPER_RST;
            st_q.addr_lo <= ADDR_LOWER_RST;
            st_q.rx_length_limit_field <= RFL_RST;
            st_q.rx_st <= RX_RUN;
            // The link pin idles high; starting the sync stages there avoids a false
            // toggle after reset. A link that is down at reset still flags one change.
            st_q.link_s1 <= 1'b1;
            st_q.link_s2 <= 1'b1;
            st_q.link_prev <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign apb_rsp = st_q.rsp;
    assign irq = st_q.irq;
    assign mdc = st_q.mgmt_clk;
    assign mdio_o = st_q.mgmt_out;
    assign mdio_oe = st_q.mgmt_dir;
    assign rx_out = st_q.out;
    assign station_addr = {st_q.addr_hi, st_q.addr_lo};

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_write_done(logic [APB_AW-1:0] ofs);
        access && apb_rsp.pready && apb_req.pwrite && apb_req.paddr == ofs;
    endsequence

    sequence s_read_done(logic [APB_AW-1:0] ofs);
        access && apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == ofs;
    endsequence

    a_irq_needs_enable: assert property (
        irq |-> (st_q.flags & st_q.enable) != 3'h0)
        else $error("interrupt raised without an enabled flag");

    a_irq_link_map: assert property (
        st_q.flags[EV_LINK_POS] && st_q.enable[EV_LINK_POS] |-> irq)
        else $error("enabled link flag did not raise the interrupt");

    a_enable_reset_zero: assert property (@(posedge clk) disable iff (1'b0)
        $rose(rst_n) |-> st_q.enable == 3'h0)
        else $error("enables not zero after reset");

    a_reserved_reads_zero: assert property (
        s_read_done(OFS_EVENT_ENABLE) |-> apb_rsp.prdata[31:3] == 29'h0)
        else $error("reserved enable bits read non-zero");

    a_mdio_release: assert property (
        s_write_done(OFS_MGMT_PORT) ##0 !apb_req.pwdata[MGMT_DIR_POS] |=> !mdio_oe)
        else $error("MDIO still driven in read direction");

    a_mdc_follows_write: assert property (
        s_write_done(OFS_MGMT_PORT) |=> mdc == $past(apb_req.pwdata[MGMT_MDC_POS]))
        else $error("MDC does not follow the written bit");

    a_link_toggle_flag: assert property (
        $changed(st_q.link_s2) |=> ##1 st_q.flags[EV_LINK_POS])
        else $error("link toggle did not set the flag");

    a_flag_zero_write_keeps: assert property (
        s_write_done(OFS_EVENT_FLAGS) ##0 st_q.flags[EV_WAKE_POS]
        && !apb_req.pwdata[EV_WAKE_POS] |=> st_q.flags[EV_WAKE_POS])
        else $error("writing zero cleared a flag");

    a_retry_saturates: assert property (
        st_q.retry == '1 && !(commit_wr && apb_req.paddr == OFS_RETRY_COUNT)
        |=> st_q.retry == '1)
        else $error("retry counter wrapped");

    a_retry_clear: assert property (
        s_write_done(OFS_RETRY_COUNT) ##0 !tx_retry_fail |=> st_q.retry == '0)
        else $error("retry counter not cleared by write");

    a_retry_count_up: assert property (
        tx_retry_fail && st_q.retry != '1 && !commit_wr
        |=> st_q.retry == $past(st_q.retry) + 1'b1)
        else $error("retry counter did not count");

    a_rx_limit_drop: assert property (
        st_q.rx_st == RX_RUN && rx_in.valid && st_q.rx_cnt >= {4'h0, limit}
        |=> !rx_out.valid)
        else $error("byte beyond the limit was kept");

    a_crc_withheld: assert property (
        st_q.rx_st == RX_RUN && rx_in.valid && rx_in.last && st_q.rx_cnt < {4'h0, limit}
        |=> rx_out.done ##1 !rx_out.valid)
        else $error("held CRC bytes were passed on");

    // ------------------------------------------------------------------
    // Register map and pin checks
    // ------------------------------------------------------------------

    a_irq_wake_map: assert property (
        st_q.flags[EV_WAKE_POS] && st_q.enable[EV_WAKE_POS] |-> irq)
        else $error("enabled wake flag did not raise the interrupt");

    a_station_addr_map: assert property (
        s_write_done(OFS_ADDR_UPPER) |=> station_addr[47:16] == $past(apb_req.pwdata))
        else $error("upper address bits not in place");

    a_addr_lo_reserved: assert property (
        s_read_done(OFS_ADDR_LOWER) |-> apb_rsp.prdata[31:16] == 16'h0000)
        else $error("reserved lower address bits read non-zero");

    a_mdio_drive: assert property (
        s_write_done(OFS_MGMT_PORT) ##0 apb_req.pwdata[MGMT_DIR_POS]
        |=> mdio_oe && mdio_o == $past(apb_req.pwdata[MGMT_OUT_POS]))
        else $error("MDIO not driven with the data-out bit");

    a_link_monitor_read: assert property (
        s_read_done(OFS_LINK_STATUS) |-> apb_rsp.prdata == {31'h0, !$past(st_q.link_s2)})
        else $error("link monitor bit does not follow the pin");

endmodule : eth_mac_ctrl_regs
